// ---- pkg/del_pkg.sv ----
package del_pkg;
  // Error codes run from one upward; bit k of a fault vector is code k+1.
  localparam int NUM_CODES = 12;
  localparam int CODE_W = 4;
  localparam logic [3:0] CODE_MOTOR_TEMP = 4'h1;
  localparam logic [3:0] CODE_OVERCURRENT = 4'h7;
  localparam logic [3:0] CODE_INTERNAL = 4'ha;
  localparam logic [3:0] CODE_FIELDBUS = 4'hc;
  localparam int IDX_INTERNAL = 9;
  localparam int IDX_FIELDBUS = 11;
  // Clock rate and the slow display tick.
  localparam int CLK_HZ = 50_000_000;
  localparam int TICK_MS = 10;
  localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  // Blink timing in milliseconds and its count in display ticks.
  localparam int PULSE_ON_MS = 200;
  localparam int PULSE_GAP_MS = 200;
  localparam int BURST_PAUSE_MS = 1200;
  localparam int GREEN_HALF_MS = 500;
  localparam int TMR_W = 8;
  localparam logic [7:0] PULSE_ON_TK = 8'(PULSE_ON_MS / TICK_MS);
  localparam logic [7:0] PULSE_GAP_TK = 8'(PULSE_GAP_MS / TICK_MS);
  localparam logic [7:0] BURST_PAUSE_TK = 8'(BURST_PAUSE_MS / TICK_MS);
  localparam logic [7:0] GREEN_HALF_TK = 8'(GREEN_HALF_MS / TICK_MS);
  // Recovery sequencer states.
  typedef enum logic [2:0] {
    DEL_RUN, DEL_ERR, DEL_WAIT_ON1, DEL_WAIT_OFF, DEL_WAIT_ON2
  } del_state_t;
  // Red blink code phases.
  typedef enum logic [1:0] {
    DEL_B_IDLE, DEL_B_ON, DEL_B_GAP, DEL_B_PAUSE
  } del_blink_t;
  // Everything the drive shows to the outside, registered together.
  typedef struct packed {
    logic led_green;
    logic led_red;
    logic ready_relay;
    logic power_stage_en;
    logic controller_en;
    logic [3:0] code;
  } del_status_t;
endpackage : del_pkg

// ---- logic/del_drive_error_latch.sv ----
// Notes on behaviour
// - Ready but not enabled: green blinks, red dark.
// - Ready and enabled: green steady, red dark.
// - Error latched: green off, red shows code.
// - Faults stay latched after cause vanishes.
// - Any latched error switches power stage off.
// - Red pulses per burst equal error code.
// - Only highest priority error is shown.
// - Recovery needs cause gone, then enable toggling.
// - First off-on after fault keeps drive disabled.
// - Next enable off clears error, relay on.
// - Second off-on transition enables the drive.
// - Power cycle clears the latched errors.
// - Internal error code cleared only by power.
// - Codes one to twelve with fixed meanings.
// - Bus fault latches the fieldbus error code.
module del_drive_error_latch
#(
  parameter int TICK_CYCLES = del_pkg::TICK_CYC,
  parameter bit LOW_CODE_FIRST = 1'b1
) (
  // Clock and power-on reset.
  input wire logic core_clk,
  input wire logic rst,
  // Enable pin and power stage readiness.
  input wire logic drive_enable_input,
  input wire logic stage_ready,
  // Fault detectors, bit k reports code k+1, and the bus fault.
  input wire logic [del_pkg::NUM_CODES-1:0] fault_cause,
  input wire logic can_bus_fault,
  // Indicators, relay and power stage controls.
  output del_pkg::del_status_t status_reg
);
  import del_pkg::*;
  // A tick counter of this width must hold TICK_CYCLES - 1.
  localparam int DIV_W = $clog2(TICK_CYCLES + 1);
  if (TICK_CYCLES < 2) begin : g_bad_tick
    $error("TICK_CYCLES must be at least two");
  end
  if (BURST_PAUSE_TK <= PULSE_GAP_TK) begin : g_bad_pause
    $error("Burst pause must exceed the pulse gap");
  end
  // Enable synchroniser stages and the debounced level.
  logic en_s1_reg, en_s2_reg, en_s3_reg, en_level_reg, en_level_next;
  // Divider producing a one-cycle display tick.
  logic [DIV_W-1:0] div_reg, div_next;
  logic tick_reg, tick_next;
  // Sticky error latches, the merged fault vector and the recovery state.
  logic [NUM_CODES-1:0] latch_reg, latch_next, fault_vec;
  del_state_t state_reg, state_next;
  // Blink code sequencer and green blink timers.
  del_blink_t bstate_reg, bstate_next;
  logic [TMR_W-1:0] btmr_reg, btmr_next, gtmr_reg, gtmr_next;
  logic [CODE_W-1:0] bcnt_reg, bcnt_next, top_code;
  logic gphase_reg, gphase_next;
  del_status_t status_next;
  // Combinational helpers.
  logic cause_any, en_rise, en_fall, clear_evt, err_now;
  // The enable pin is asynchronous; only stages two and three are compared.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      en_s1_reg <= 1'b0;
      en_s2_reg <= 1'b0;
      en_s3_reg <= 1'b0;
    end else begin
      en_s1_reg <= drive_enable_input;
      en_s2_reg <= en_s1_reg;
      en_s3_reg <= en_s2_reg;
    end
  end
  // A change of the enable level counts once stages two and three agree.
  always_comb begin
    en_level_next = en_level_reg;
    if (en_s2_reg == en_s3_reg) begin
      en_level_next = en_s3_reg;
    end
    en_rise = en_level_next & ~en_level_reg;
    en_fall = ~en_level_next & en_level_reg;
  end
  // Display tick divider.
  always_comb begin
    div_next = div_reg + DIV_W'(1);
    tick_next = 1'b0;
    if (div_reg == DIV_W'(TICK_CYCLES - 1)) begin
      div_next = '0;
      tick_next = 1'b1;
    end
  end
  // The bus fault joins the fieldbus detector.
  always_comb begin
    fault_vec = fault_cause;
    fault_vec[IDX_FIELDBUS] = fault_cause[IDX_FIELDBUS] | can_bus_fault;
    cause_any = |fault_vec;
  end
  // Latches and recovery sequence.
  always_comb begin
    state_next = state_reg;
    clear_evt = 1'b0;
    case (state_reg)
      DEL_RUN: state_next = DEL_RUN;
      DEL_ERR: begin
        // Counting starts only with the cause gone and enable off.
        if (!cause_any && !en_level_reg && !latch_reg[IDX_INTERNAL]) begin
          state_next = DEL_WAIT_ON1;
        end
      end
      DEL_WAIT_ON1: begin
        if (cause_any) begin
          state_next = DEL_ERR;
        end else if (en_rise) begin
          state_next = DEL_WAIT_OFF;
        end
      end
      DEL_WAIT_OFF: begin
        if (cause_any) begin
          state_next = DEL_ERR;
        end else if (en_fall) begin
          clear_evt = 1'b1;
          state_next = DEL_WAIT_ON2;
        end
      end
      DEL_WAIT_ON2: begin
        if (en_rise) begin
          state_next = DEL_RUN;
        end
      end
      default: begin
        state_next = DEL_ERR;
      end
    endcase
    // A fault arriving with the clear still latches; internal error stays.
    latch_next = latch_reg | fault_vec;
    if (clear_evt) begin
      latch_next = (latch_reg & (NUM_CODES'(1) << IDX_INTERNAL))
                   | fault_vec;
    end
    err_now = |latch_next;
    if (cause_any) begin
      state_next = DEL_ERR;
    end
  end
  // Priority encoder: lower code wins unless the parameter flips it.
  always_comb begin
    top_code = '0;
    for (int k = 0; k < NUM_CODES; k++) begin
      if (latch_next[k] && (!LOW_CODE_FIRST || top_code == '0)) begin
        top_code = CODE_W'(k + 1);
      end
    end
  end
  // Red burst sequencer: code pulses, gaps, then a long dark pause.
  always_comb begin
    bstate_next = bstate_reg;
    btmr_next = btmr_reg;
    bcnt_next = bcnt_reg;
    if (!err_now) begin
      bstate_next = DEL_B_IDLE;
    end else if (bstate_reg == DEL_B_IDLE) begin
      bstate_next = DEL_B_ON;
      btmr_next = PULSE_ON_TK;
      bcnt_next = top_code;
    end else if (tick_reg) begin
      btmr_next = btmr_reg - TMR_W'(1);
      if (btmr_reg <= TMR_W'(1)) begin
        case (bstate_reg)
          DEL_B_ON: begin
            bstate_next = DEL_B_GAP;
            btmr_next = PULSE_GAP_TK;
            bcnt_next = bcnt_reg - CODE_W'(1);
          end
          DEL_B_GAP: begin
            if (bcnt_reg == '0) begin
              bstate_next = DEL_B_PAUSE;
              btmr_next = BURST_PAUSE_TK;
            end else begin
              bstate_next = DEL_B_ON;
              btmr_next = PULSE_ON_TK;
            end
          end
          default: begin
            // A new burst picks up the code currently on top.
            bstate_next = DEL_B_ON;
            btmr_next = PULSE_ON_TK;
            bcnt_next = top_code;
          end
        endcase
      end
    end
  end
  // Green blinking runs freely; it is only shown while ready and idle.
  always_comb begin
    gtmr_next = gtmr_reg;
    gphase_next = gphase_reg;
    if (tick_reg) begin
      gtmr_next = gtmr_reg - TMR_W'(1);
      if (gtmr_reg <= TMR_W'(1)) begin
        gtmr_next = GREEN_HALF_TK;
        gphase_next = ~gphase_reg;
      end
    end
  end
  // Outputs are computed from next state so a fault drops power at once.
  always_comb begin
    status_next.power_stage_en = (state_next == DEL_RUN) & en_level_next
                                 & stage_ready & ~err_now;
    status_next.controller_en = status_next.power_stage_en;
    status_next.ready_relay = ~err_now;
    status_next.led_red = err_now & (bstate_next == DEL_B_ON);
    status_next.code = err_now ? top_code : '0;
    if (err_now) begin
      status_next.led_green = 1'b0;
    end else if (status_next.power_stage_en) begin
      status_next.led_green = 1'b1;
    end else begin
      status_next.led_green = stage_ready & gphase_reg;
    end
  end
  // All state registers but the enable synchroniser; reset models the mains power cycle.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      en_level_reg <= 1'b0;
      div_reg <= '0;
      tick_reg <= 1'b0;
      latch_reg <= '0;
      state_reg <= DEL_RUN;
      bstate_reg <= DEL_B_IDLE;
      btmr_reg <= '0;
      bcnt_reg <= '0;
      gtmr_reg <= GREEN_HALF_TK;
      gphase_reg <= 1'b0;
      status_reg <= '0;
    end else begin
      en_level_reg <= en_level_next;
      div_reg <= div_next;
      tick_reg <= tick_next;
      latch_reg <= latch_next;
      state_reg <= state_next;
      bstate_reg <= bstate_next;
      btmr_reg <= btmr_next;
      bcnt_reg <= bcnt_next;
      gtmr_reg <= gtmr_next;
      gphase_reg <= gphase_next;
      status_reg <= status_next;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  chk_latch_sticky: assert property (
    latch_reg[0] && !clear_evt |=> latch_reg[0])
    else $error("Latched error vanished without a clear");
  chk_stage_off_err: assert property (
    |latch_reg |-> !status_reg.power_stage_en && !status_reg.controller_en)
    else $error("Power stage on while an error is latched");
  chk_green_off_err: assert property (
    |latch_reg |-> !status_reg.led_green && status_reg.code != 4'h0)
    else $error("Green lit or no code during error");
  chk_green_on_run: assert property (
    status_reg.power_stage_en |-> status_reg.led_green && !status_reg.led_red)
    else $error("Enabled drive not showing steady green");
  chk_red_dark_ok: assert property (
    !(|latch_reg) && !$past(rst)
    |-> !status_reg.led_red && status_reg.ready_relay)
    else $error("Red lit or relay off without an error");
  chk_internal_kept: assert property (
    latch_reg[IDX_INTERNAL] |=> latch_reg[IDX_INTERNAL])
    else $error("Internal error cleared without power cycle");
  chk_first_on_off: assert property (
    state_reg == DEL_WAIT_ON1 && !cause_any && en_rise
    |=> state_reg == DEL_WAIT_OFF && !status_reg.power_stage_en)
    else $error("First enable transition did not stay disabled");
  chk_clear_relay: assert property (
    state_reg == DEL_WAIT_OFF && !cause_any && en_fall && !tick_reg
    |=> status_reg.ready_relay && status_reg.code == 4'h0)
    else $error("Enable off did not clear the error");
  chk_second_on: assert property (
    state_reg == DEL_WAIT_ON2 && !en_rise |=> state_reg != DEL_RUN)
    else $error("Drive re-armed without second transition");
  chk_cause_blocks: assert property (
    state_reg == DEL_ERR && cause_any |=> state_reg == DEL_ERR)
    else $error("Recovery started with fault still present");
  chk_fieldbus_bus: assert property (
    can_bus_fault |=> latch_reg[IDX_FIELDBUS] ##0 status_reg.code != 4'h0)
    else $error("Bus fault not latched as fieldbus error");
  chk_top_code: assert property (
    latch_reg[0] && LOW_CODE_FIRST |-> status_reg.code == CODE_MOTOR_TEMP)
    else $error("Highest priority code not shown");
  chk_burst_red: assert property (
    bstate_reg inside {DEL_B_GAP, DEL_B_PAUSE} |-> !status_reg.led_red)
    else $error("Red lit between pulses");
  cov_err_latch: cover property (!(|latch_reg) ##1 (|latch_reg));
  cov_rearm: cover property (state_reg == DEL_WAIT_ON2 ##1
                             state_reg == DEL_RUN);
  cov_pause: cover property (bstate_reg == DEL_B_PAUSE);
  cov_enabled: cover property ($rose(status_reg.power_stage_en));
endmodule : del_drive_error_latch

// ---- sim/del_enable_driver.sv ----
// Operator switch on the enable pin, seen as the drive sees it.
module del_enable_driver (
  // Drive clock.
  input wire logic core_clk,
  // Switch position that the operator wants.
  input wire logic want_on,
  // The enable pin itself.
  output logic drive_enable_input
);
  timeunit 1ns;
  timeprecision 1ps;
  // The pin starts OFF, as it must be before the drive is powered up.
  initial drive_enable_input = 1'b0;
  // The switch moves half a cycle after the wish, on the next rising edge; the drive
  // synchronises the pin, so this lag matters only to the bench timing.
  always @(posedge core_clk) begin
    drive_enable_input <= want_on;
  end
endmodule : del_enable_driver

// ---- sim/test_drive_error_latch_status.sv ----
// Self-checking bench for the error latch, recovery and status display.
module test_drive_error_latch_status import del_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // Short display tick keeps the blink checks cheap.
  localparam int TK = 4;
  localparam int GAP = int'(PULSE_GAP_TK) * TK;
  // Stimulus, all driven at the falling edge.
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic want_on = 1'b0;
  logic stage_ready = 1'b0;
  logic can_bus_fault = 1'b0;
  logic [NUM_CODES-1:0] fault_cause = '0;
  logic drive_enable_input;
  del_status_t st;
  // Counters for the verdict.
  int num_errors = 0;
  int checks_done = 0;

  del_drive_error_latch #(.TICK_CYCLES(TK), .LOW_CODE_FIRST(1'b1))
    u_del_drive_error_latch (.core_clk(core_clk), .rst(rst),
    .drive_enable_input(drive_enable_input), .stage_ready(stage_ready),
    .fault_cause(fault_cause), .can_bus_fault(can_bus_fault),
    .status_reg(st));
  del_enable_driver u_del_enable_driver (.core_clk(core_clk),
    .want_on(want_on), .drive_enable_input(drive_enable_input));

  // Clock of 20 ns period.
  initial begin
    forever #10 core_clk = ~core_clk;
  end

  // Compare one value and count it.
  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic wait_cyc(int n);
    repeat (n) @(negedge core_clk);
  endtask : wait_cyc

  // Mains off and on: inputs quiet, reset for four cycles.
  task automatic power_cycle;
    @(negedge core_clk);
    rst = 1'b1;
    fault_cause = '0;
    can_bus_fault = 1'b0;
    want_on = 1'b0;
    wait_cyc(4);
    rst = 1'b0;
    wait_cyc(8);
    check("code after power", st.code, 8'h0);
  endtask : power_cycle

  // Move the switch and give the pin synchroniser time to settle.
  task automatic set_en(logic v);
    @(negedge core_clk);
    want_on = v;
    wait_cyc(8);
  endtask : set_en

  // A fault that lasts a single clock.
  task automatic pulse_fault(int idx);
    @(negedge core_clk);
    fault_cause[idx] = 1'b1;
    wait_cyc(1);
    fault_cause = '0;
    wait_cyc(2);
  endtask : pulse_fault

  task automatic t_ready;
    int hi;
    int lo;
    int red;
    hi = 0;
    lo = 0;
    red = 0;
    repeat (500) begin
      @(negedge core_clk);
      if (st.led_green === 1'b1) hi++;
      if (st.led_green === 1'b0) lo++;
      if (st.led_red !== 1'b0) red++;
    end
    check("green lit phase", 8'(hi > 0), 8'h1);
    check("green dark phase", 8'(lo > 0), 8'h1);
    check("red while ready", 8'(red), 8'h0);
    check("power while off", st.power_stage_en, 1'b0);
    set_en(1'b1);
    check("green enabled", st.led_green, 1'b1);
    check("red enabled", st.led_red, 1'b0);
    check("power enabled", st.power_stage_en, 1'b1);
    check("ctrl enabled", st.controller_en, 1'b1);
    $display("test ready done");
  endtask : t_ready

  task automatic t_latch;
    int rises;
    int dark;
    int mx;
    logic prv;
    rises = 0;
    dark = 0;
    mx = 0;
    prv = 1'b0;
    pulse_fault(6);
    check("code held", st.code, CODE_OVERCURRENT);
    check("power off", st.power_stage_en, 1'b0);
    check("ctrl off", st.controller_en, 1'b0);
    check("relay off", st.ready_relay, 1'b0);
    check("green off", st.led_green, 1'b0);
    repeat (1500) begin
      @(negedge core_clk);
      if (st.led_red === 1'b1) begin
        if (prv !== 1'b1) rises++;
        dark = 0;
      end else begin
        dark++;
        if (dark > mx) mx = dark;
      end
      prv = st.led_red;
    end
    check("red pulses", 8'(rises), 8'h7);
    check("pause over gap", 8'(mx > GAP), 8'h1);
    $display("test latch done");
  endtask : t_latch

  task automatic t_recover;
    @(negedge core_clk);
    fault_cause[6] = 1'b1;
    set_en(1'b0);
    set_en(1'b1);
    set_en(1'b0);
    set_en(1'b1);
    check("cause present", st.power_stage_en, 1'b0);
    check("code stays", st.code, CODE_OVERCURRENT);
    fault_cause = '0;
    set_en(1'b0);
    set_en(1'b1);
    check("first on power", st.power_stage_en, 1'b0);
    check("first on ctrl", st.controller_en, 1'b0);
    set_en(1'b0);
    check("relay back", st.ready_relay, 1'b1);
    check("code cleared", st.code, 8'h0);
    set_en(1'b1);
    check("second on power", st.power_stage_en, 1'b1);
    check("second on ctrl", st.controller_en, 1'b1);
    $display("test recover done");
  endtask : t_recover

  task automatic t_codes;
    for (int k = 0; k < NUM_CODES; k++) begin
      power_cycle();
      pulse_fault(k);
      check("code value", st.code, 8'(k + 1));
    end
    power_cycle();
    @(negedge core_clk);
    can_bus_fault = 1'b1;
    wait_cyc(1);
    can_bus_fault = 1'b0;
    wait_cyc(2);
    check("bus code", st.code, CODE_FIELDBUS);
    check("bus power", st.power_stage_en, 1'b0);
    power_cycle();
    @(negedge core_clk);
    fault_cause = 12'h041;
    can_bus_fault = 1'b1;
    wait_cyc(2);
    check("priority code", st.code, CODE_MOTOR_TEMP);
    $display("test codes done");
  endtask : t_codes

  task automatic t_internal;
    power_cycle();
    pulse_fault(IDX_INTERNAL);
    set_en(1'b0);
    set_en(1'b1);
    set_en(1'b0);
    set_en(1'b1);
    check("internal kept", st.code, CODE_INTERNAL);
    check("internal power", st.power_stage_en, 1'b0);
    power_cycle();
    $display("test internal done");
  endtask : t_internal

  // Verdict and end of run.
  task automatic wrap_up;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : wrap_up

  // Main sequence.
  initial begin
    wait_cyc(4);
    rst = 1'b0;
    stage_ready = 1'b1;
    wait_cyc(8);
    t_ready();
    t_latch();
    t_recover();
    t_codes();
    t_internal();
    wrap_up();
  end

  // The tests need about 2400 cycles; a hang is cut off well after that.
  initial begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    wrap_up();
  end
endmodule : test_drive_error_latch_status
